// file: src/acr_clock_div.sv
// Converter clock divider: one enable pulse per (divider+1) source ticks.
// Assumes sourceTick is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module acr_clock_div
  import acr_pkg::*;
#(
  parameter int DIV_W = ACR_DIV_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sourceTick,
  input wire logic [DIV_W-1:0] divider,
  output logic converterClock
);

  logic [DIV_W-1:0] tickCount;
  logic [DIV_W-1:0] next_tickCount;
  wire logic wrapNow;

  // divider is read live, so a new value already sets the length of the period in progress
  assign wrapNow = sourceTick && (tickCount >= divider);
  assign next_tickCount = wrapNow ? '0 :
    (sourceTick ? DIV_W'(tickCount + 1'b1) : tickCount);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickCount <= '0;
      converterClock <= 1'b0;
    end else begin
      tickCount <= next_tickCount; // R2
      converterClock <= wrapNow; // R1
    end
  end

endmodule // acr_clock_div
`default_nettype wire

// file: src/acr_config.sv
// Converter configuration: clock divider, repeat accumulation, burst
// sequencing and indirect gain access over the register bus.
// Assumes the converter core pulses sampleDone with sampleData for each
// conversion it was asked to start, and that all inputs are synchronous.
//
// Summary of operation
// (R1) Divider in config bits 7:3; converter clock is source over divider+1.
// (R2) Each divider value gives a fixed integer division of the source.
// (R3) Software rounds the divider quotient up so the clock never runs fast.
// (R4) Burst off: divider source is the system clock.
// (R5) Burst on: divider source is a separate clock of at most 30 MHz.
// (R6) Repeat count in bits 2:1 sets conversions summed before events.
// (R7) Encoding 00 gives one, 01 four, 10 eight conversions.
// (R8) Outside burst, every conversion needs its own start trigger.
// (R9) In burst, one trigger runs the whole sequence self-timed.
// (R10) Both modes sum the sequence into the 16-bit result pair.
// (R11) Software keeps left justify off whenever repeat count is not 00.
// (R12) Config bit 0 enables gain-register programming mode.
// (R13) Encoding 11 gives sixteen conversions filling the high result byte.
// (R14) In gain mode high byte writes set address, low byte writes send data.
// (R15) Gain registers are write-only; reads never return gain values.
// (R16) Accumulator clears at first conversion; done only after the last.
// (R17) Window compare runs once on the accumulated result per sequence.
`timescale 1ns/1ns
`default_nettype none
module acr_config
  import acr_pkg::*;
#(
  parameter int SAMPLE_W = ACR_SAMPLE_W,
  parameter int ACC_W = ACR_ACC_W
) (
  input wire logic clock,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  output logic [7:0] sfrRdData,
  // control bits held outside this block
  input wire logic burstModeEnable,
  input wire logic leftJustifySelect,
  input wire logic startTrigger,
  input wire logic burstSourceTick,
  input wire logic [ACC_W-1:0] windowLow,
  input wire logic [ACC_W-1:0] windowHigh,
  // converter core
  output logic converterClock,
  output logic sampleStart,
  input wire logic sampleDone,
  input wire logic [SAMPLE_W-1:0] sampleData,
  output logic gainAccessEnable,
  output logic gainWrite,
  output logic [7:0] gainAddr,
  output logic [7:0] gainData,
  // events
  output logic conversionDoneFlag,
  output logic windowCompareFlag,
  output logic sequenceBusy
);

  // ************************************************************
  // decoding helpers
  // ************************************************************
  function automatic logic [ACR_CNT_W-1:0] repeatTarget(
    input logic [1:0] code
  );
    logic [ACR_CNT_W-1:0] result;
    result = ACR_CNT_1;
    case (code)
      ACR_RPT_1: result = ACR_CNT_1;
      ACR_RPT_4: result = ACR_CNT_4;
      ACR_RPT_8: result = ACR_CNT_8;
      ACR_RPT_16: result = ACR_CNT_16;
      default: result = ACR_CNT_1;
    endcase
    return result;
  endfunction

  function automatic logic hitAddr(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction

  // ************************************************************
  // configuration register
  // ************************************************************
  logic [7:0] converterConfig;
  wire logic [ACR_DIV_W-1:0] sarClockDivider;
  wire logic [1:0] repeatCountField;
  wire logic gainEnableBit;
  wire logic wrConfig;
  wire logic wrResHigh;
  wire logic wrResLow;

  assign sarClockDivider = converterConfig[ACR_DIV_MSB:ACR_DIV_LSB]; // R1
  assign repeatCountField = converterConfig[ACR_RPT_MSB:ACR_RPT_LSB]; // R6
  assign gainEnableBit = converterConfig[ACR_GAIN_BIT]; // R12
  assign wrConfig = sfrWrite && hitAddr(sfrAddr, ACR_ADDR_CONFIG);
  assign wrResHigh = sfrWrite && hitAddr(sfrAddr, ACR_ADDR_RES_HIGH);
  assign wrResLow = sfrWrite && hitAddr(sfrAddr, ACR_ADDR_RES_LOW);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      converterConfig <= ACR_CONFIG_RESET;
      gainAccessEnable <= 1'b0;
    end else begin
      if (wrConfig) begin
        converterConfig <= sfrWrData;
      end
      // follows the stored bit in the same cycle it is written, still from a flop
      gainAccessEnable <= wrConfig ? sfrWrData[ACR_GAIN_BIT] :
        gainEnableBit; // R12
    end
  end

  // ************************************************************
  // converter clock
  // ************************************************************
  wire logic dividerSourceTick;

  // without burst every system clock edge is a source tick
  assign dividerSourceTick = burstModeEnable ? burstSourceTick :
    1'b1; // R4 R5

  acr_clock_div #(
    .DIV_W(ACR_DIV_W)
  ) u_clock_div (
    .clock(clock),
    .rst_b(rst_b),
    .sourceTick(dividerSourceTick),
    .divider(sarClockDivider),
    .converterClock(converterClock)
  );

  // ************************************************************
  // repeat sequencer
  // ************************************************************
  acr_state_t state;
  acr_state_t next_state;
  logic [ACR_CNT_W-1:0] doneCount;
  logic [ACR_CNT_W-1:0] target;
  logic [ACC_W-1:0] accum;
  logic [ACC_W-1:0] resultWord;
  wire logic [ACC_W-1:0] sumNow;
  wire logic lastSample;
  wire logic seqStart;
  wire logic finishNow;
  wire logic inWindow;
  wire logic issueStart;

  assign sumNow = ACC_W'(accum + ACC_W'(sampleData)); // R10
  assign lastSample = (ACR_CNT_W'(doneCount + 1'b1) >= target);
  assign seqStart = (state == ACR_ST_IDLE) && startTrigger;
  assign finishNow = (state == ACR_ST_CONVERT) && sampleDone
    && lastSample; // R16
  assign inWindow = (sumNow >= windowLow) && (sumNow <= windowHigh);
  // next conversion: own timing in burst, a fresh trigger otherwise
  assign issueStart = seqStart
    || ((state == ACR_ST_CONVERT) && sampleDone && !lastSample
        && burstModeEnable) // R9
    || ((state == ACR_ST_WAIT_TRIG) && startTrigger); // R8

  always_comb begin
    next_state = state;
    case (state)
      ACR_ST_IDLE: begin
        if (startTrigger) begin
          next_state = ACR_ST_CONVERT;
        end
      end
      ACR_ST_CONVERT: begin
        if (sampleDone) begin
          if (lastSample) begin
            next_state = ACR_ST_IDLE;
          end else if (!burstModeEnable) begin
            next_state = ACR_ST_WAIT_TRIG; // R8
          end
        end
      end
      ACR_ST_WAIT_TRIG: begin
        if (startTrigger) begin
          next_state = ACR_ST_CONVERT;
        end
      end
      default: next_state = ACR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ACR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // repeat length is latched per sequence so a mid-sequence write
  // cannot strand the count past its target
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      doneCount <= '0;
      target <= ACR_CNT_1;
      accum <= '0;
    end else if (seqStart) begin
      doneCount <= '0;
      target <= repeatTarget(repeatCountField); // R7 R13
      accum <= '0; // R16
    end else if ((state == ACR_ST_CONVERT) && sampleDone) begin
      doneCount <= ACR_CNT_W'(doneCount + 1'b1);
      accum <= sumNow; // R10
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sampleStart <= 1'b0;
      conversionDoneFlag <= 1'b0;
      windowCompareFlag <= 1'b0;
      sequenceBusy <= 1'b0;
    end else begin
      sampleStart <= issueStart; // R8 R9
      conversionDoneFlag <= finishNow; // R6 R16
      windowCompareFlag <= finishNow && inWindow; // R17
      sequenceBusy <= (next_state != ACR_ST_IDLE);
    end
  end

  // ************************************************************
  // result pair and indirect gain access
  // ************************************************************
  wire logic gainAddrWrite;
  wire logic gainDataWrite;

  assign gainAddrWrite = wrResHigh && gainEnableBit; // R14
  assign gainDataWrite = wrResLow && gainEnableBit; // R14

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resultWord <= '0;
    end else if (finishNow) begin
      resultWord <= sumNow; // R10 R13
    end else if (wrResHigh && !gainEnableBit) begin
      resultWord[ACC_W-1:8] <= sfrWrData;
    end else if (wrResLow && !gainEnableBit) begin
      resultWord[7:0] <= sfrWrData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gainAddr <= '0;
      gainData <= '0;
      gainWrite <= 1'b0;
    end else begin
      if (gainAddrWrite) begin
        gainAddr <= sfrWrData; // R14
      end
      if (gainDataWrite) begin
        gainData <= sfrWrData; // R14
      end
      gainWrite <= gainDataWrite;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire logic useLeftJustify;
  wire logic [ACC_W-1:0] leftWord;
  wire logic [7:0] readHigh;
  wire logic [7:0] readLow;
  logic [7:0] next_sfrRdData;

  // left justify only makes sense for a single 12-bit sample
  assign useLeftJustify = leftJustifySelect
    && (repeatCountField == ACR_RPT_1); // R11
  assign leftWord = {resultWord[SAMPLE_W-1:0], {ACR_LJ_PAD{1'b0}}};
  // gain registers are never read back; result bytes show instead
  assign readHigh = useLeftJustify ? leftWord[ACC_W-1:8] :
    resultWord[ACC_W-1:8]; // R15
  assign readLow = useLeftJustify ? leftWord[7:0] :
    resultWord[7:0]; // R15

  always_comb begin
    next_sfrRdData = sfrRdData;
    if (sfrRead) begin
      if (hitAddr(sfrAddr, ACR_ADDR_CONFIG)) begin
        next_sfrRdData = converterConfig;
      end else if (hitAddr(sfrAddr, ACR_ADDR_RES_HIGH)) begin
        next_sfrRdData = readHigh;
      end else if (hitAddr(sfrAddr, ACR_ADDR_RES_LOW)) begin
        next_sfrRdData = readLow;
      end else begin
        next_sfrRdData = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdData <= '0;
    end else begin
      sfrRdData <= next_sfrRdData;
    end
  end

endmodule // acr_config
`default_nettype wire

// file: src/acr_pkg.sv
// Constants shared by the converter configuration block.
// Assumes an 8-bit special-function-register bus with registers at the
// byte addresses given here.
package acr_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ACR_ADDR_CONFIG = 8'hBC;
  localparam logic [7:0] ACR_ADDR_RES_LOW = 8'hBD;
  localparam logic [7:0] ACR_ADDR_RES_HIGH = 8'hBE;

  // ************************************************************
  // converter_config fields and reset
  // ************************************************************
  localparam logic [7:0] ACR_CONFIG_RESET = 8'hF8;
  localparam int ACR_DIV_MSB = 7;
  localparam int ACR_DIV_LSB = 3;
  localparam int ACR_RPT_MSB = 2;
  localparam int ACR_RPT_LSB = 1;
  localparam int ACR_GAIN_BIT = 0;
  localparam int ACR_DIV_W = 5;

  // ************************************************************
  // repeat count encodings and conversion counts
  // ************************************************************
  localparam logic [1:0] ACR_RPT_1 = 2'h0;
  localparam logic [1:0] ACR_RPT_4 = 2'h1;
  localparam logic [1:0] ACR_RPT_8 = 2'h2;
  localparam logic [1:0] ACR_RPT_16 = 2'h3;
  localparam int ACR_CNT_W = 5;
  localparam logic [4:0] ACR_CNT_1 = 5'h01;
  localparam logic [4:0] ACR_CNT_4 = 5'h04;
  localparam logic [4:0] ACR_CNT_8 = 5'h08;
  localparam logic [4:0] ACR_CNT_16 = 5'h10;

  // ************************************************************
  // data widths and result formatting
  // ************************************************************
  localparam int ACR_SAMPLE_W = 12;
  localparam int ACR_ACC_W = 16;
  localparam int ACR_LJ_PAD = 4;

  // ************************************************************
  // clocks
  // ************************************************************
  localparam int ACR_SYS_CLOCK_HZ = 20_000_000;
  localparam int ACR_BURST_SRC_MAX_HZ = 30_000_000;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'b00,
    ACR_ST_CONVERT = 2'b01,
    ACR_ST_WAIT_TRIG = 2'b10
  } acr_state_t;

endpackage

// file: verification/acr_config_chk.sv
// Port checker for acr_config.
// Assumes one clock domain and one-cycle bus strobes.
`timescale 1ns/1ns
`default_nettype none
module acr_config_chk
  import acr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrRdData,
  input wire logic burstModeEnable,
  input wire logic startTrigger,
  input wire logic burstSourceTick,
  input wire logic converterClock,
  input wire logic sampleStart,
  input wire logic sampleDone,
  input wire logic gainAccessEnable,
  input wire logic gainWrite,
  input wire logic [7:0] gainAddr,
  input wire logic [7:0] gainData,
  input wire logic conversionDoneFlag,
  input wire logic windowCompareFlag,
  input wire logic sequenceBusy
);
  logic [7:0] cfg;
  logic [5:0] gap;
  logic seen;
  logic [4:0] nDone;
  logic [1:0] code;
  wire logic cfgWr = sfrWrite && sfrAddr == ACR_ADDR_CONFIG;
  wire logic hiW = gainAccessEnable && sfrWrite
    && sfrAddr == ACR_ADDR_RES_HIGH;
  wire logic loW = gainAccessEnable && sfrWrite && sfrAddr == ACR_ADDR_RES_LOW;
  wire logic idleTrig = startTrigger && !sequenceBusy;

  // period is only trusted from the second pulse after a change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= ACR_CONFIG_RESET;
      gap <= '0;
      seen <= 1'b0;
      nDone <= '0;
      code <= '0;
    end else begin
      if (cfgWr) cfg <= sfrWrData;
      if (idleTrig) code <= cfg[2:1];
      if (idleTrig) nDone <= '0;
      else if (sampleDone) nDone <= nDone + 5'h01;
      if (cfgWr || burstModeEnable) seen <= 1'b0;
      else if (converterClock) seen <= 1'b1;
      if (cfgWr || converterClock) gap <= '0;
      else gap <= gap + 6'h01;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  div_period_a: assert property (
    converterClock && seen && !burstModeEnable |-> gap == {1'b0, cfg[7:3]})
    else $error("converter clock period wrong");
  // in burst the converter clock may only pulse the cycle after a tick of the separate source
  burst_src_a: assert property (
    converterClock && $past(burstModeEnable) |-> $past(burstSourceTick))
    else $error("converter clock without burst tick");
  cfg_read_a: assert property (
    sfrRead && sfrAddr == ACR_ADDR_CONFIG |=> sfrRdData == $past(cfg))
    else $error("config readback wrong");
  gain_mirror_a: assert property (
    cfgWr |=> gainAccessEnable == $past(sfrWrData[0]))
    else $error("gain enable wrong");
  gain_addr_a: assert property (
    hiW |=> gainAddr == $past(sfrWrData))
    else $error("gain address wrong");
  gain_data_a: assert property (
    loW |=> gainWrite && gainData == $past(sfrWrData))
    else $error("gain data wrong");
  gain_only_a: assert property (
    gainWrite |-> $past(loW))
    else $error("stray gain write");
  start_nb_a: assert property (
    sampleStart && !burstModeEnable |-> $past(startTrigger))
    else $error("start without trigger");
  start_burst_a: assert property (
    sampleStart |-> $past(startTrigger) || $past(sampleDone))
    else $error("stray start");
  trig_resp_a: assert property (
    idleTrig |=> sampleStart && sequenceBusy)
    else $error("trigger not answered");
  done_last_a: assert property (
    conversionDoneFlag |-> $past(sampleDone) && !sequenceBusy)
    else $error("done too early");
  repeat_cnt_a: assert property (
    conversionDoneFlag |-> nDone == ((code == 2'h0) ? ACR_CNT_1 : 5'h02 << code))
    else $error("repeat count wrong");
  win_once_a: assert property (
    windowCompareFlag |-> conversionDoneFlag)
    else $error("window flag outside done");

  cover property (conversionDoneFlag && windowCompareFlag);
  cover property (converterClock && burstModeEnable);
  cover property (gainWrite);
  cover property (sampleStart && burstModeEnable && $past(sampleDone));
endmodule // acr_config_chk
`default_nettype wire

// file: verification/acr_core_model.sv
// Behavioural converter core: one sample per sampleStart, fast or slow.
// Assumes sampleStart is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module acr_core_model (
  input wire logic clock,
  input wire logic sampleStart,
  input wire logic slow,
  input wire logic [11:0] base,
  output logic sampleDone,
  output logic [11:0] sampleData
);
  initial begin
    sampleDone = 1'b0;
    sampleData = 12'hFFF;
    forever begin
      @(posedge clock);
      if (sampleStart === 1'b1) begin
        repeat (slow ? 4 : 1) @(posedge clock);
        sampleDone <= 1'b1;
        sampleData <= base;
        @(posedge clock);
        sampleDone <= 1'b0;
        // data is not held past the strobe
        sampleData <= ~base;
      end
    end
  end
endmodule // acr_core_model
`default_nettype wire

// file: verification/test_adc_clock_repeat_config.sv
// Self-checking bench for acr_config with a behavioural core.
// Assumes a 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED t=%0t %h vs %h", $time, g, e); end end
module test_adc_clock_repeat_config
  import acr_pkg::*;
;
  logic clock, rst_b, sfrWrite, sfrRead, startTrigger, slow, rdWas;
  logic burstModeEnable, leftJustifySelect, burstSourceTick;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, gainAddr, gainData;
  logic [15:0] windowLow, windowHigh, lastRes;
  logic [11:0] sampleData, base;
  logic converterClock, sampleStart, sampleDone, gainAccessEnable;
  logic gainWrite, conversionDoneFlag, windowCompareFlag, sequenceBusy;
  int n_fail, samples_checked, cyc;
  logic [7:0] qRd[$];
  logic [15:0] qGain[$];
  logic qWin[$];
  logic [15:0] gv[3] = '{16'h046C, 16'h07A0, 16'h0801};

  acr_config dut (.*);
  acr_core_model core (.*);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic close_out();
    // a result still awaited means a sequence or strobe never came
    if (qRd.size() + qGain.size() + qWin.size() != 0) n_fail++;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  always @(posedge clock) rdWas <= (sfrRead === 1'b1);
  always @(negedge clock) begin
    burstSourceTick = 1'($urandom);
    if (rdWas) `CHK(sfrRdData, qRd.pop_front())
    if (gainWrite === 1'b1)
      `CHK({gainAddr, gainData}, qGain.pop_front())
    if (conversionDoneFlag === 1'b1)
      `CHK(windowCompareFlag, qWin.pop_front())
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    sfrAddr = a;
    sfrRead = 1'b1;
    qRd.push_back(e);
    @(negedge clock);
    sfrRead = 1'b0;
  endtask

  task automatic runSeq(input logic [1:0] code, input logic burst,
    input logic lj);
    int n;
    int wt;
    n = (code == 2'h0) ? 1 : 2 << code;
    wr(ACR_ADDR_CONFIG, {5'($urandom % 4), code, 1'b0});
    base = 12'($urandom);
    slow = 1'($urandom);
    burstModeEnable = burst;
    leftJustifySelect = lj;
    lastRes = 16'(n) * {4'h0, base};
    // odd codes miss the window by one at the lower bound
    windowLow = lastRes + 16'(code[0]);
    windowHigh = burst ? 16'hFFFF : lastRes;
    qWin.push_back(!code[0]);
    for (int i = 0; i < n; i++) begin
      if (!burst || i == 0) begin
        @(negedge clock);
        startTrigger = 1'b1;
        @(negedge clock);
        startTrigger = 1'b0;
      end
      wt = 0;
      while (sampleDone !== 1'b1 && wt < 40) begin
        @(negedge clock);
        wt++;
      end
      @(negedge clock);
    end
    wt = 0;
    while (sequenceBusy !== 1'b0 && wt < 40) begin
      @(negedge clock);
      wt++;
    end
    rd(ACR_ADDR_RES_HIGH, lj ? base[11:4] : lastRes[15:8]);
    rd(ACR_ADDR_RES_LOW, lj ? {base[3:0], 4'h0} : lastRes[7:0]);
  endtask

  initial begin
    {sfrAddr, sfrWrData, sfrWrite, sfrRead, startTrigger, slow} = '0;
    {burstModeEnable, leftJustifySelect} = '0;
    {windowLow, windowHigh, base, lastRes} = '0;
    {n_fail, samples_checked, cyc} = '0;
    rst_b = 1'b0;
    void'($urandom(54593));
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    rd(ACR_ADDR_CONFIG, ACR_CONFIG_RESET);
    rd(ACR_ADDR_RES_HIGH, 8'h00);
    wr(8'hBB, 8'h55);
    rd(8'hBB, 8'h00);
    rd(ACR_ADDR_CONFIG, ACR_CONFIG_RESET);
    for (int c = 0; c < 8; c++) runSeq(2'(c), c[2], c == 4);
    wr(ACR_ADDR_CONFIG, 8'h01);
    foreach (gv[i]) begin
      qGain.push_back(gv[i]);
      wr(ACR_ADDR_RES_HIGH, gv[i][15:8]);
      wr(ACR_ADDR_RES_LOW, gv[i][7:0]);
    end
    rd(ACR_ADDR_RES_HIGH, lastRes[15:8]);
    wr(ACR_ADDR_CONFIG, 8'h00);
    wr(ACR_ADDR_RES_LOW, 8'h5A);
    rd(ACR_ADDR_RES_LOW, 8'h5A);
    rd(ACR_ADDR_CONFIG, 8'h00);
    repeat (4) @(negedge clock);
    close_out();
  end
endmodule // test_adc_clock_repeat_config

bind acr_config acr_config_chk u_chk (.*);
`default_nettype wire
